// [rtl/pfs_pkg.sv]
// package: register map, field layout and carrier types of the pin function selector
package pfs_pkg;

	localparam int REG_W = 16;
	localparam int NUM_REGS = 4;
	localparam int NUM_PINS = 10;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [31:0] PA_LOW_SEL2_IDX = 32'hFFFF838E;
	localparam logic [31:0] PB_DIR_IDX = 32'hFFFF8394;
	localparam logic [31:0] PB_SEL1_IDX = 32'hFFFF8398;
	localparam logic [31:0] PB_SEL2_IDX = 32'hFFFF839A;
	localparam logic [31:0] PA_LOW_SEL2_ADDR = PA_LOW_SEL2_IDX << 2;
	localparam logic [31:0] PB_DIR_ADDR = PB_DIR_IDX << 2;
	localparam logic [31:0] PB_SEL1_ADDR = PB_SEL1_IDX << 2;
	localparam logic [31:0] PB_SEL2_ADDR = PB_SEL2_IDX << 2;

	// storage slots
	localparam logic [1:0] SLOT_PA_SEL2 = 2'h0;
	localparam logic [1:0] SLOT_PB_DIR = 2'h1;
	localparam logic [1:0] SLOT_PB_SEL1 = 2'h2;
	localparam logic [1:0] SLOT_PB_SEL2 = 2'h3;

	// writable bits; the rest read as zero
	localparam logic [15:0] PA_SEL2_MASK = 16'hFD75;
	localparam logic [15:0] PB_DIR_MASK = 16'h03FF;
	localparam logic [15:0] PB_SEL1_MASK = 16'h000F;
	localparam logic [15:0] PB_SEL2_MASK = 16'hFFF5;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// field positions (low bit of each field)
	localparam int A7_POS = 14;
	localparam int A6_POS = 12;
	localparam int A5_POS = 10;
	localparam int A4_POS = 8;
	localparam int A3_POS = 6;
	localparam int A2_POS = 4;
	localparam int A1_POS = 2;
	localparam int A0_POS = 0;
	localparam int B9_POS = 2;
	localparam int B8_POS = 0;
	localparam int B9_DIR_POS = 9;
	localparam int B8_DIR_POS = 8;

	// pin slots in the pin vectors: A0..A7 then B8, B9
	localparam int PIN_B8 = 8;
	localparam int PIN_B9 = 9;

	// two-bit selection codes
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_FN1 = 2'h1;
	localparam logic [1:0] SEL_FN2 = 2'h2;
	localparam logic [1:0] SEL_FN3 = 2'h3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic [NUM_PINS-1:0] out;
		logic [NUM_PINS-1:0] oe;
	} pfs_pin_drive_s;

	// peripheral-facing levels taken from the pins
	typedef struct packed {
		logic timerExtClockA;
		logic timerExtClockB;
		logic serial0Clock;
		logic serial1Clock;
		logic serial0Receive;
		logic serial1Receive;
		logic dmaRequest0;
		logic dmaRequest1;
		logic interruptRequest0;
		logic interruptRequest1;
		logic interruptRequest6;
		logic interruptRequest7;
		logic waitRequest;
		logic [NUM_PINS-1:0] gpioIn;
	} pfs_periph_in_s;

	// levels the peripherals want on the pins
	typedef struct packed {
		logic chipSelect2;
		logic chipSelect3;
		logic serial0Clock;
		logic serial0ClockOe;
		logic serial1Clock;
		logic serial1ClockOe;
		logic serial0Transmit;
		logic serial1Transmit;
		logic addressLine20;
		logic addressLine21;
	} pfs_periph_out_s;

endpackage

// [rtl/pfs_pin_select.sv]
// pin function selector for port A pins 0..7 and port B pins 8, 9
// Summary of operation
// RULE_01: pin A7 field 15:14 selects GPIO, timer clock B, chip select 3, reserved.
// RULE_02: pin A6 field 13:12 selects GPIO, timer clock A, chip select 2, reserved.
// RULE_03: pin A5 field 11:10 selects GPIO, serial1 clock, DMA request 1, interrupt 1.
// RULE_04: pin A4 bit 8 selects GPIO or serial1 transmit output.
// RULE_05: pin A3 bit 6 selects GPIO or serial1 receive input.
// RULE_06: pin A2 field 5:4 selects GPIO, serial0 clock, DMA request 0, interrupt 0.
// RULE_07: pin A1 bit 2 selects GPIO or serial0 transmit output.
// RULE_08: pin A0 bit 0 selects GPIO or serial0 receive input.
// RULE_09: pin B9 field 3:2 selects GPIO, interrupt 7, address line 21, reserved.
// RULE_10: pin B8 field 1:0 selects GPIO, interrupt 6, address line 20, wait input.
// RULE_11: all selection fields reset to zero, so every pin starts as GPIO.
// RULE_12: single-chip mode keeps chip select, DMA and address selections as GPIO.
// RULE_13: single-chip mode keeps pin B8 GPIO for address 20 or wait selections.
// RULE_14: reserved codes are not for software; reserved bits read zero, ignore writes.
// RULE_15: port B direction bit 1 makes GPIO an output, 0 input; resets input.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module pfs_pin_select
	import pfs_pkg::*;
#(
	parameter int PIN_COUNT = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// operating mode
	input wire logic singleChipMode,
	// general i/o data and port A direction from the port logic
	input wire logic [7:0] portAOut,
	input wire logic [7:0] portADir,
	input wire logic [1:0] portBOut,
	// peripheral side
	input wire pfs_pkg::pfs_periph_out_s periphOut,
	output pfs_pkg::pfs_periph_in_s periphIn,
	// package pins
	input wire logic [pfs_pkg::NUM_PINS-1:0] pinIn,
	output pfs_pkg::pfs_pin_drive_s pinDrive
);
	import pfs_pkg::*;

	// elaboration guard: routing is written for exactly ten pins
	if (PIN_COUNT != NUM_PINS) begin : g_badPinCount
		$error("pfs_pin_select serves exactly ten pins");
	end

	logic [REG_W-1:0] regs_reg [NUM_REGS];
	logic dataPhase_reg;
	logic dataWrite_reg;
	logic [1:0] dataSlot_reg;
	logic dataHit_reg;

	logic addrHit_next;
	logic [1:0] addrSlot_next;
	logic [REG_W-1:0] rdValue_next;
	logic takeAddr;

	pfs_pin_drive_s pinDrive_next;
	pfs_periph_in_s periphIn_next;

	logic [1:0] selA7, selA6, selA5, selA2, selB9, selB8;
	logic selA4, selA3, selA1, selA0;
	logic [PIN_COUNT-1:0] gpioOut;
	logic [PIN_COUNT-1:0] gpioDir;

	function automatic logic [REG_W-1:0] slot_mask(input logic [1:0] slot);
		logic [REG_W-1:0] m;
		m = PB_SEL2_MASK;
		if (slot == SLOT_PA_SEL2) begin
			m = PA_SEL2_MASK;
		end else if (slot == SLOT_PB_DIR) begin
			m = PB_DIR_MASK;
		end else if (slot == SLOT_PB_SEL1) begin
			m = PB_SEL1_MASK;
		end
		return m;
	endfunction

	// address phase decode
	assign takeAddr = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

	always_comb begin
		addrHit_next = 1'b1;
		addrSlot_next = SLOT_PB_SEL2;
		if (haddr == PA_LOW_SEL2_ADDR) begin
			addrSlot_next = SLOT_PA_SEL2;
		end else if (haddr == PB_DIR_ADDR) begin
			addrSlot_next = SLOT_PB_DIR;
		end else if (haddr == PB_SEL1_ADDR) begin
			addrSlot_next = SLOT_PB_SEL1;
		end else if (haddr == PB_SEL2_ADDR) begin
			addrSlot_next = SLOT_PB_SEL2;
		end else begin
			addrHit_next = 1'b0;
		end
	end

	// read value; a write in its data phase is forwarded to a read right behind it
	always_comb begin
		rdValue_next = regs_reg[addrSlot_next];
		if (dataPhase_reg && dataWrite_reg && dataHit_reg && dataSlot_reg == addrSlot_next) begin
			rdValue_next = hwdata[REG_W-1:0] & slot_mask(addrSlot_next); // RULE_14
		end
		if (!addrHit_next) begin
			rdValue_next = '0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dataPhase_reg <= 1'b0;
			dataWrite_reg <= 1'b0;
			dataSlot_reg <= SLOT_PA_SEL2;
			dataHit_reg <= 1'b0;
		end else if (hready) begin
			dataPhase_reg <= takeAddr;
			dataWrite_reg <= takeAddr && hwrite;
			dataSlot_reg <= addrSlot_next;
			dataHit_reg <= takeAddr && addrHit_next;
		end
	end

	// zero-wait slave, always okay
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			hrdata <= 32'h00000000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			if (takeAddr && !hwrite) begin
				hrdata <= {16'h0000, rdValue_next};
			end
		end
	end

	// register storage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_reg[i] <= REG_RESET; // RULE_11 RULE_15
			end
		end else if (dataPhase_reg && dataWrite_reg && dataHit_reg) begin
			regs_reg[dataSlot_reg] <= hwdata[REG_W-1:0] & slot_mask(dataSlot_reg); // RULE_14
		end
	end

	// field extraction
	always_comb begin
		selA7 = regs_reg[SLOT_PA_SEL2][A7_POS +: 2];
		selA6 = regs_reg[SLOT_PA_SEL2][A6_POS +: 2];
		selA5 = regs_reg[SLOT_PA_SEL2][A5_POS +: 2];
		selA4 = regs_reg[SLOT_PA_SEL2][A4_POS];
		selA3 = regs_reg[SLOT_PA_SEL2][A3_POS];
		selA2 = regs_reg[SLOT_PA_SEL2][A2_POS +: 2];
		selA1 = regs_reg[SLOT_PA_SEL2][A1_POS];
		selA0 = regs_reg[SLOT_PA_SEL2][A0_POS];
		selB9 = regs_reg[SLOT_PB_SEL1][B9_POS +: 2];
		selB8 = regs_reg[SLOT_PB_SEL1][B8_POS +: 2];
	end

	assign gpioOut = {portBOut, portAOut};
	// port B general i/o direction from the direction register
	assign gpioDir = {regs_reg[SLOT_PB_DIR][B9_DIR_POS], regs_reg[SLOT_PB_DIR][B8_DIR_POS],
		portADir}; // RULE_15

	// pin routing; unselected peripheral inputs idle high
	always_comb begin
		pinDrive_next.out = gpioOut;
		pinDrive_next.oe = gpioDir;
		periphIn_next = '1;
		periphIn_next.gpioIn = pinIn;

		case (selA7)
			SEL_FN1: begin
				pinDrive_next.oe[7] = 1'b0; // RULE_01
				periphIn_next.timerExtClockB = pinIn[7];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_12
					pinDrive_next.out[7] = periphOut.chipSelect3; // RULE_01
					pinDrive_next.oe[7] = 1'b1;
				end
			end
			default: begin
			end
		endcase

		case (selA6)
			SEL_FN1: begin
				pinDrive_next.oe[6] = 1'b0; // RULE_02
				periphIn_next.timerExtClockA = pinIn[6];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_12
					pinDrive_next.out[6] = periphOut.chipSelect2; // RULE_02
					pinDrive_next.oe[6] = 1'b1;
				end
			end
			default: begin
			end
		endcase

		case (selA5)
			SEL_FN1: begin
				pinDrive_next.out[5] = periphOut.serial1Clock; // RULE_03
				pinDrive_next.oe[5] = periphOut.serial1ClockOe;
				periphIn_next.serial1Clock = pinIn[5];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_12
					pinDrive_next.oe[5] = 1'b0; // RULE_03
					periphIn_next.dmaRequest1 = pinIn[5];
				end
			end
			SEL_FN3: begin
				pinDrive_next.oe[5] = 1'b0; // RULE_03
				periphIn_next.interruptRequest1 = pinIn[5];
			end
			default: begin
			end
		endcase

		if (selA4) begin
			pinDrive_next.out[4] = periphOut.serial1Transmit; // RULE_04
			pinDrive_next.oe[4] = 1'b1;
		end
		if (selA3) begin
			pinDrive_next.oe[3] = 1'b0; // RULE_05
			periphIn_next.serial1Receive = pinIn[3];
		end

		case (selA2)
			SEL_FN1: begin
				pinDrive_next.out[2] = periphOut.serial0Clock; // RULE_06
				pinDrive_next.oe[2] = periphOut.serial0ClockOe;
				periphIn_next.serial0Clock = pinIn[2];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_12
					pinDrive_next.oe[2] = 1'b0; // RULE_06
					periphIn_next.dmaRequest0 = pinIn[2];
				end
			end
			SEL_FN3: begin
				pinDrive_next.oe[2] = 1'b0; // RULE_06
				periphIn_next.interruptRequest0 = pinIn[2];
			end
			default: begin
			end
		endcase

		if (selA1) begin
			pinDrive_next.out[1] = periphOut.serial0Transmit; // RULE_07
			pinDrive_next.oe[1] = 1'b1;
		end
		if (selA0) begin
			pinDrive_next.oe[0] = 1'b0; // RULE_08
			periphIn_next.serial0Receive = pinIn[0];
		end

		case (selB9)
			SEL_FN1: begin
				pinDrive_next.oe[PIN_B9] = 1'b0; // RULE_09
				periphIn_next.interruptRequest7 = pinIn[PIN_B9];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_12
					pinDrive_next.out[PIN_B9] = periphOut.addressLine21; // RULE_09
					pinDrive_next.oe[PIN_B9] = 1'b1;
				end
			end
			default: begin
			end
		endcase

		case (selB8)
			SEL_FN1: begin
				pinDrive_next.oe[PIN_B8] = 1'b0; // RULE_10
				periphIn_next.interruptRequest6 = pinIn[PIN_B8];
			end
			SEL_FN2: begin
				if (!singleChipMode) begin // RULE_13
					pinDrive_next.out[PIN_B8] = periphOut.addressLine20; // RULE_10
					pinDrive_next.oe[PIN_B8] = 1'b1;
				end
			end
			SEL_FN3: begin
				if (!singleChipMode) begin // RULE_13
					pinDrive_next.oe[PIN_B8] = 1'b0; // RULE_10
					periphIn_next.waitRequest = pinIn[PIN_B8];
				end
			end
			default: begin
			end
		endcase
	end

	// registered pin and peripheral outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinDrive <= '0;
			periphIn <= '1;
		end else begin
			pinDrive <= pinDrive_next;
			periphIn <= periphIn_next;
		end
	end

endmodule // pfs_pin_select

// [verification/pfs_pin_select_monitor.sv]
// port relation checker of the pin function selector
`timescale 1ns/10ps
module pfs_pin_select_monitor
	import pfs_pkg::*;
#(
	parameter int PIN_COUNT = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// mode and pins
	input wire logic singleChipMode,
	input wire logic [pfs_pkg::NUM_PINS-1:0] pinIn,
	input wire pfs_pkg::pfs_periph_in_s periphIn,
	input wire pfs_pkg::pfs_pin_drive_s pinDrive
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	chk_bus_answer: assert property (hreadyout && !hresp && hrdata[31:16] == 16'h0)
		else $error("bus answer wrong");
	chk_reset_idle: assert property ($past(reset) |-> pinDrive == '0 && periphIn == '1)
		else $error("pins not idle after reset");
	chk_gpio_delay: assert property (!$past(reset) |-> periphIn.gpioIn == $past(pinIn))
		else $error("gpio input not one cycle late");
	chk_dma_gate: assert property (!periphIn.dmaRequest0 |-> !$past(singleChipMode)
		&& !pinDrive.oe[2] && periphIn.interruptRequest0 && periphIn.serial0Clock)
		else $error("dma request passed wrongly");
	chk_wait_gate: assert property (!periphIn.waitRequest |-> !$past(singleChipMode)
		&& !pinDrive.oe[8] && periphIn.interruptRequest6)
		else $error("wait request passed wrongly");
	chk_rx0_input: assert property (!periphIn.serial0Receive |-> !pinDrive.oe[0]
		&& !$past(pinIn[0]))
		else $error("receive 0 pin wrong");
	chk_rx1_input: assert property (!periphIn.serial1Receive |-> !pinDrive.oe[3]
		&& !$past(pinIn[3]))
		else $error("receive 1 pin wrong");
	chk_timer_input: assert property (!periphIn.timerExtClockA |-> !pinDrive.oe[6]
		&& !$past(pinIn[6]))
		else $error("timer clock pin wrong");
endmodule // pfs_pin_select_monitor
bind pfs_pin_select pfs_pin_select_monitor #(.PIN_COUNT(PIN_COUNT)) i_mon (.clk(clk),
	.reset(reset), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.singleChipMode(singleChipMode), .pinIn(pinIn), .periphIn(periphIn), .pinDrive(pinDrive));

// [verification/pfs_far_side.sv]
// pads and peripherals around the pin function selector
`timescale 1ns/10ps
module pfs_far_side
	import pfs_pkg::*;
(
	// clock
	input wire logic clk,
	// selector drive
	input wire pfs_pkg::pfs_pin_drive_s pinDrive,
	// levels towards the selector
	output pfs_pkg::pfs_periph_out_s periphOut,
	output logic [pfs_pkg::NUM_PINS-1:0] pinIn
);
	logic [NUM_PINS-1:0] padLevel = '0;
	logic [9:0] outBits = '0;
	always @(posedge clk) begin
		padLevel <= NUM_PINS'($urandom);
		outBits <= 10'($urandom);
	end
	assign periphOut = outBits;
	// driven pads read back the driven level
	assign pinIn = (pinDrive.oe & pinDrive.out) | (~pinDrive.oe & padLevel);
endmodule // pfs_far_side

// [verification/tb_port_pin_function_select.sv]
// self-checking bench of the pin function selector
`timescale 1ns/10ps
module tb_port_pin_function_select;
	import pfs_pkg::*;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic singleChipMode = 1'h0;
	logic [7:0] portAOut = '0;
	logic [7:0] portADir = '0;
	logic [1:0] portBOut = '0;
	logic hreadyout, hresp;
	logic armed = 1'h0;
	logic [31:0] hrdata, rd;
	logic [15:0] pa, pbDir, pb1, pb2;
	pfs_periph_out_s po;
	pfs_periph_in_s periphIn, expI;
	logic [NUM_PINS-1:0] pinIn;
	pfs_pin_drive_s pinDrive, expD;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] adr [5] = '{PA_LOW_SEL2_ADDR, PB_DIR_ADDR, PB_SEL1_ADDR, PB_SEL2_ADDR,
		PA_LOW_SEL2_ADDR + 32'h4};
	wire ext = !singleChipMode;
	pfs_pin_select #(.PIN_COUNT(NUM_PINS)) i_dut (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.singleChipMode(singleChipMode), .portAOut(portAOut), .portADir(portADir),
		.portBOut(portBOut), .periphOut(po), .periphIn(periphIn), .pinIn(pinIn),
		.pinDrive(pinDrive));
	pfs_far_side i_far (.clk(clk), .pinDrive(pinDrive), .periphOut(po), .pinIn(pinIn));
	initial forever #2.5 clk = ~clk;
	function automatic pfs_pin_drive_s fDrv();
		pfs_pin_drive_s d;
		d.out = {portBOut, portAOut};
		d.oe = {pbDir[9:8], portADir};
		d.oe[0] &= !pa[0];
		d.oe[3] &= !pa[6];
		if (pa[2]) d.out[1] = po.serial0Transmit;
		if (pa[8]) d.out[4] = po.serial1Transmit;
		d.oe[1] |= pa[2];
		d.oe[4] |= pa[8];
		if (pa[5:4] == SEL_FN1) d.out[2] = po.serial0Clock;
		if (pa[5:4] == SEL_FN1) d.oe[2] = po.serial0ClockOe;
		if (pa[5:4] == SEL_FN3 || (pa[5:4] == SEL_FN2 && ext)) d.oe[2] = 1'h0;
		if (pa[11:10] == SEL_FN1) d.out[5] = po.serial1Clock;
		if (pa[11:10] == SEL_FN1) d.oe[5] = po.serial1ClockOe;
		if (pa[11:10] == SEL_FN3 || (pa[11:10] == SEL_FN2 && ext)) d.oe[5] = 1'h0;
		if (pa[13:12] == SEL_FN1) d.oe[6] = 1'h0;
		if (pa[13:12] == SEL_FN2 && ext) d.out[6] = po.chipSelect2;
		d.oe[6] |= pa[13:12] == SEL_FN2 && ext;
		if (pa[15:14] == SEL_FN1) d.oe[7] = 1'h0;
		if (pa[15:14] == SEL_FN2 && ext) d.out[7] = po.chipSelect3;
		d.oe[7] |= pa[15:14] == SEL_FN2 && ext;
		if (pb1[1:0] == SEL_FN1 || (pb1[1:0] == SEL_FN3 && ext)) d.oe[8] = 1'h0;
		if (pb1[1:0] == SEL_FN2 && ext) d.out[8] = po.addressLine20;
		d.oe[8] |= pb1[1:0] == SEL_FN2 && ext;
		if (pb1[3:2] == SEL_FN1) d.oe[9] = 1'h0;
		if (pb1[3:2] == SEL_FN2 && ext) d.out[9] = po.addressLine21;
		d.oe[9] |= pb1[3:2] == SEL_FN2 && ext;
		return d;
	endfunction
	function automatic pfs_periph_in_s fIn();
		pfs_periph_in_s p;
		p.gpioIn = pinIn;
		p.timerExtClockA = pa[13:12] != SEL_FN1 | pinIn[6];
		p.timerExtClockB = pa[15:14] != SEL_FN1 | pinIn[7];
		p.serial0Clock = pa[5:4] != SEL_FN1 | pinIn[2];
		p.dmaRequest0 = !(pa[5:4] == SEL_FN2 && ext) | pinIn[2];
		p.interruptRequest0 = pa[5:4] != SEL_FN3 | pinIn[2];
		p.serial1Clock = pa[11:10] != SEL_FN1 | pinIn[5];
		p.dmaRequest1 = !(pa[11:10] == SEL_FN2 && ext) | pinIn[5];
		p.interruptRequest1 = pa[11:10] != SEL_FN3 | pinIn[5];
		p.serial0Receive = !pa[0] | pinIn[0];
		p.serial1Receive = !pa[6] | pinIn[3];
		p.interruptRequest6 = pb1[1:0] != SEL_FN1 | pinIn[8];
		p.waitRequest = !(pb1[1:0] == SEL_FN3 && ext) | pinIn[8];
		p.interruptRequest7 = pb1[3:2] != SEL_FN1 | pinIn[9];
		return p;
	endfunction
	function automatic logic [31:0] fReg(input logic [31:0] a);
		case (a)
			PA_LOW_SEL2_ADDR: return {16'h0, pa};
			PB_DIR_ADDR: return {16'h0, pbDir};
			PB_SEL1_ADDR: return {16'h0, pb1};
			PB_SEL2_ADDR: return {16'h0, pb2};
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd = hrdata;
		if (w) case (a)
			PA_LOW_SEL2_ADDR: pa <= d[15:0] & PA_SEL2_MASK;
			PB_DIR_ADDR: pbDir <= d[15:0] & PB_DIR_MASK;
			PB_SEL1_ADDR: pb1 <= d[15:0] & PB_SEL1_MASK;
			PB_SEL2_ADDR: pb2 <= d[15:0] & PB_SEL2_MASK;
			default: ;
		endcase
	endtask
	task automatic wrRd(input logic [31:0] a, input logic [31:0] d);
		// keep reserved codes off the selection fields
		if (a == PA_LOW_SEL2_ADDR || a == PB_SEL1_ADDR) d &= ~{16'h0, d[14], 1'h0, d[12],
			9'h0, d[2], 3'h0};
		bus(a, 1'h1, d);
		bus(a, 1'h0, 32'h0);
		chk(rd, fReg(a));
	endtask
	task automatic doReset();
		reset <= 1'h1;
		{pa, pbDir, pb1, pb2} <= '0;
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			bus(adr[i], 1'h0, 32'h0);
			chk(rd, 32'h0);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		expD <= fDrv();
		expI <= fIn();
		armed <= !reset;
		portAOut <= 8'($urandom);
		portADir <= 8'($urandom);
		portBOut <= 2'($urandom);
	end
	always @(negedge clk) begin
		if (armed && !reset) begin
			chk(32'(pinDrive), 32'(expD));
			chk(32'(periphIn), 32'(expI));
		end
	end
	initial begin
		void'($urandom(32'hBACAD1B7));
		doReset();
		for (int i = 0; i < 8; i++) begin
			singleChipMode <= i[2];
			wrRd(PA_LOW_SEL2_ADDR, 32'({8{i[1:0]}}));
			wrRd(PB_SEL1_ADDR, 32'({2{i[1:0]}}));
			wrRd(PB_DIR_ADDR, 32'hFFFF);
			repeat (6) @(posedge clk);
		end
		repeat (300) begin
			singleChipMode <= 1'($urandom);
			wrRd(adr[$urandom_range(4)], $urandom);
		end
		doReset();
		tally_and_finish();
	end
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule // tb_port_pin_function_select
